// ==== hdl/codec_cmd_pkg.sv ====
/*
 * constants and carrier types for the serial command port of the two-channel codec.
 * assumes one 125 MHz clock; all pins are sampled into that domain first.
 */
`default_nettype none
package codec_cmd_pkg;
    // command codes
    localparam logic [7:0] CMD_DEACTIVATE = 8'h00;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h02;
    localparam logic [7:0] CMD_IDLE = 8'h06;
    localparam logic [7:0] CMD_NORMAL = 8'h08;
    localparam logic [7:0] CMD_ACTIVATE = 8'h0e;
    localparam logic [7:0] CMD_MCLK_2M = 8'h10;
    localparam logic [7:0] CMD_MCLK_4M = 8'h12;
    localparam logic [7:0] CMD_WR_TX_SLOT = 8'h40;
    localparam logic [7:0] CMD_RD_TX_SLOT = 8'h41;
    localparam logic [7:0] CMD_WR_RX_SLOT = 8'h42;
    localparam logic [7:0] CMD_RD_RX_SLOT = 8'h43;
    localparam logic [7:0] CMD_WR_CLK_SLOT = 8'h44;
    localparam logic [7:0] CMD_RD_CLK_SLOT = 8'h45;
    localparam logic [7:0] CMD_WR_GAINS = 8'h50;
    localparam logic [7:0] CMD_RD_GAINS = 8'h51;
    localparam logic [7:0] CMD_WR_LINE_OUT = 8'h52;
    localparam logic [7:0] CMD_RD_LINE_PINS = 8'h53;
    localparam logic [7:0] CMD_WR_LINE_DIR = 8'h54;
    // defined-bit masks of each data byte
    localparam logic [7:0] MASK_SLOT = 8'hff;
    localparam logic [7:0] MASK_CLK_SLOT = 8'h7f;
    localparam logic [7:0] MASK_GAINS = 8'hff;
    localparam logic [7:0] MASK_LINE = 8'h1f;
    // field positions
    localparam int CLK_EDGE_BIT = 6;
    localparam int GAIN_DELAY_BIT = 7;
    localparam int GAIN_TX_BIT = 6;
    localparam int GAIN_RX_BIT = 5;
    localparam logic [4:0] SCALE_CUTOFF = 5'h00;
    localparam logic [4:0] SCALE_LOOPBACK = 5'h10;
    // bits per byte and frame pulses before valid transmit data
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] FRAMES_TO_VALID = 2'h2;
    // reset values
    localparam logic [7:0] SLOT_RESET = 8'h00;
    localparam logic [7:0] GAINS_RESET = 8'h00;
    localparam logic [4:0] LINE_RESET = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WDATA = 2'b01,
        ST_RDATA = 2'b10
    } port_state_t;

    // per-channel settings seen by the rest of the codec
    typedef struct packed {
        logic [7:0] tx_slot;
        logic [7:0] rx_slot;
        logic [5:0] bit_offsets;
        logic [7:0] gains;
        logic active;
        logic tx_valid;
        logic filters_on;
        logic adaptive_on;
        logic mu_law;
        logic rx_extra_loss;
        logic tx_cutoff;
        logic rx_cutoff;
        logic hpf_on;
        logic test_on;
        logic scale_cutoff;
        logic loopback;
    } chan_cfg_t;
endpackage
`default_nettype wire

// ==== hdl/pin_sampler.sv ====
/*
 * two-flop sampler with edge detection for a group of pin inputs.
 * assumes inputs are asynchronous to clk_i; edges come in the same cycle as the new level.
 */
`default_nettype none
module pin_sampler #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins
    input wire logic [W-1:0] pin_i,
    // sampled level and edges
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] meta;
    logic [W-1:0] prev;

    ////////////////////////////////////////////////////////////////////////////
    // two stages, then a history stage for the edge detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '1;
            level_o <= '1;
            prev <= '1;
        end else begin
            meta <= pin_i;
            level_o <= meta;
            prev <= level_o;
        end
    end

    assign rise_o = level_o & ~prev;
    assign fall_o = ~level_o & prev;
endmodule
`default_nettype wire

// ==== hdl/byte_shifter.sv ====
/*
 * serial byte shifter: captures on the serial clock rising edge, launches on falling.
 * assumes edge strobes from pin_sampler; load_i arrives with the select falling strobe.
 */
`default_nettype none
module byte_shifter (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // strobes
    input wire logic start_i,
    input wire logic sclk_rise_i,
    input wire logic sclk_fall_i,
    input wire logic selected_i,
    // data
    input wire logic din_i,
    input wire logic [7:0] load_i,
    output logic [7:0] rx_byte_o,
    output logic [3:0] bit_cnt_o,
    output logic dout_o
);
    logic [7:0] tx_sh;

    ////////////////////////////////////////////////////////////////////////////
    // capture msb first and count bits of the select period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_byte_o <= 8'h00;
            bit_cnt_o <= 4'h0;
        end else if (start_i) begin
            bit_cnt_o <= 4'h0;
        end else if (selected_i && sclk_rise_i) begin
            rx_byte_o <= {rx_byte_o[6:0], din_i};
            if (bit_cnt_o != 4'hf) begin
                bit_cnt_o <= bit_cnt_o + 4'h1;
            end
        end
    end

    // launch msb at select start, next bit on each falling edge after a capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_sh <= 8'h00;
            dout_o <= 1'b0;
        end else if (start_i) begin
            tx_sh <= load_i;
            dout_o <= load_i[7];
        end else if (selected_i && sclk_fall_i && bit_cnt_o != 4'h0) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
            dout_o <= tx_sh[6];
        end
    end
endmodule
`default_nettype wire

// ==== hdl/codec_command_port.sv ====
/*
 * command interpreter of the host serial port for a two-channel voice codec.
 * assumes the host drives serial clock and selects; frame marker from the highway.
 */
`default_nettype none
// What this block does
// - bytes shifted msb first both directions
// - command byte, then one data byte in or out
// - read bytes follow; commands ignored meanwhile
// - undefined read bits are driven zero
// - anomalous select period acts as idle command
// - select rises advance bytes; idle clock harmless
// - both selects low write both channels
// - deactivate gives standby, settings kept
// - software reset restores standby defaults
// - normal conditions clear loss, cutoffs, tests
// - activate; transmit valid after second frame
// - master clock choice shared by channels
// - slot commands store slot and highway
// - bit offsets and shared launch edge
// - delay bit plus analog gain selections
// - scaling code, cutoff and loopback codes
// - line outputs latched, driven when output
// - line read returns actual pin levels
// - direction bits: one is output
module codec_command_port #(
    parameter int LINE_PINS = 5
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // host serial port
    input wire logic serial_clock_i,
    input wire logic chan1_select_n_i,
    input wire logic chan2_select_n_i,
    input wire logic shared_serial_line_i,
    output logic shared_serial_line_o,
    output logic shared_serial_line_oe_o,
    // highway timing
    input wire logic frame_marker_i,
    // line control pins, per channel
    input wire logic [1:0][LINE_PINS-1:0] line_ctrl_pins_i,
    output logic [1:0][LINE_PINS-1:0] line_ctrl_pins_o,
    output logic [1:0][LINE_PINS-1:0] line_ctrl_pins_oe_o,
    // settings
    output codec_cmd_pkg::chan_cfg_t [1:0] chan_cfg_o,
    output logic mclk_4m_o,
    output logic launch_rise_o
);
    if (LINE_PINS < 1 || LINE_PINS > 5) begin : g_check
        $error("LINE_PINS must be 1 to 5");
    end

    logic sclk_rise, sclk_fall, din, frame_rise, serial_clock_unused, frame_unused;
    logic [2 * LINE_PINS:0] rise_unused;
    logic [1:0] sel_n, sel_n_fall, sel_n_rise;
    logic [1:0][LINE_PINS-1:0] pin_level;
    logic any_sel, start, finish, whole_byte;
    logic [1:0] chan_mask;
    logic [7:0] rx_byte, load_byte, cmd;
    logic [3:0] bit_cnt;
    logic dout, exec, wr_exec;
    codec_cmd_pkg::port_state_t state;
    logic [1:0][LINE_PINS-1:0] line_latch, line_dir;
    logic [1:0][1:0] frame_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling
    pin_sampler #(.W(3)) u_port_pins (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i({serial_clock_i, chan2_select_n_i, chan1_select_n_i}),
        .level_o({serial_clock_unused, sel_n}),
        .rise_o({sclk_rise, sel_n_rise}),
        .fall_o({sclk_fall, sel_n_fall})
    );

    pin_sampler #(.W(2 + 2 * LINE_PINS)) u_misc_pins (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i({frame_marker_i, shared_serial_line_i, line_ctrl_pins_i}),
        .level_o({frame_unused, din, pin_level}),
        .rise_o({frame_rise, rise_unused}),
        .fall_o()
    );

    // a select period starts when either select falls with none low before
    assign any_sel = ~&sel_n;
    assign start = |sel_n_fall && &(sel_n | sel_n_fall);
    assign finish = any_sel == 1'b0 && |sel_n_rise;
    assign whole_byte = bit_cnt == codec_cmd_pkg::BYTE_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // byte shifter
    byte_shifter u_shift (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(start),
        .sclk_rise_i(sclk_rise),
        .sclk_fall_i(sclk_fall),
        .selected_i(any_sel),
        .din_i(din),
        .load_i(load_byte),
        .rx_byte_o(rx_byte),
        .bit_cnt_o(bit_cnt),
        .dout_o(dout)
    );

    // read value of one channel, undefined bits forced low
    function automatic logic [7:0] read_value(input logic [7:0] code, input logic ch);
        logic [7:0] v;
        v = 8'h00;
        unique case (code)
            codec_cmd_pkg::CMD_RD_TX_SLOT: v = chan_cfg_o[ch].tx_slot;
            codec_cmd_pkg::CMD_RD_RX_SLOT: v = chan_cfg_o[ch].rx_slot;
            codec_cmd_pkg::CMD_RD_CLK_SLOT: v = {1'b0, launch_rise_o, chan_cfg_o[ch].bit_offsets};
            codec_cmd_pkg::CMD_RD_GAINS: v = chan_cfg_o[ch].gains;
            codec_cmd_pkg::CMD_RD_LINE_PINS: v = 8'(pin_level[ch]);
            default: v = 8'h00;
        endcase
        return v & read_mask(code);
    endfunction

    function automatic logic [7:0] read_mask(input logic [7:0] code);
        logic [7:0] m;
        m = 8'h00;
        if (code == codec_cmd_pkg::CMD_RD_CLK_SLOT) begin
            m = codec_cmd_pkg::MASK_CLK_SLOT;
        end else if (code == codec_cmd_pkg::CMD_RD_LINE_PINS) begin
            m = codec_cmd_pkg::MASK_LINE;
        end else begin
            m = codec_cmd_pkg::MASK_SLOT;
        end
        return m;
    endfunction

    function automatic logic is_write(input logic [7:0] code);
        return code == codec_cmd_pkg::CMD_WR_TX_SLOT || code == codec_cmd_pkg::CMD_WR_RX_SLOT
            || code == codec_cmd_pkg::CMD_WR_CLK_SLOT || code == codec_cmd_pkg::CMD_WR_GAINS
            || code == codec_cmd_pkg::CMD_WR_LINE_OUT || code == codec_cmd_pkg::CMD_WR_LINE_DIR;
    endfunction

    function automatic logic is_read(input logic [7:0] code);
        return code == codec_cmd_pkg::CMD_RD_TX_SLOT || code == codec_cmd_pkg::CMD_RD_RX_SLOT
            || code == codec_cmd_pkg::CMD_RD_CLK_SLOT || code == codec_cmd_pkg::CMD_RD_GAINS
            || code == codec_cmd_pkg::CMD_RD_LINE_PINS;
    endfunction

    // the read byte is loaded as the next select period opens
    assign load_byte = (state == codec_cmd_pkg::ST_RDATA)
        ? read_value(cmd, chan_mask[0] ? 1'b0 : 1'b1) : 8'h00;
    assign exec = finish && whole_byte && state == codec_cmd_pkg::ST_IDLE;
    assign wr_exec = finish && whole_byte && state == codec_cmd_pkg::ST_WDATA;

    ////////////////////////////////////////////////////////////////////////////
    // channel mask of the current period
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            chan_mask <= 2'b00;
        end else if (start) begin
            chan_mask <= ~sel_n;
        end
    end

    // sequence state: command, then one data byte in or out
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= codec_cmd_pkg::ST_IDLE;
            cmd <= codec_cmd_pkg::CMD_IDLE;
        end else if (finish) begin
            if (!whole_byte) begin
                state <= codec_cmd_pkg::ST_IDLE;
                cmd <= codec_cmd_pkg::CMD_IDLE;
            end else begin
                unique case (state)
                    codec_cmd_pkg::ST_IDLE: begin
                        cmd <= rx_byte;
                        if (is_write(rx_byte)) begin
                            state <= codec_cmd_pkg::ST_WDATA;
                        end else if (is_read(rx_byte)) begin
                            state <= codec_cmd_pkg::ST_RDATA;
                        end
                    end
                    codec_cmd_pkg::ST_WDATA: state <= codec_cmd_pkg::ST_IDLE;
                    codec_cmd_pkg::ST_RDATA: state <= codec_cmd_pkg::ST_IDLE;
                    default: state <= codec_cmd_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // drive the shared line only while a read byte goes out
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            shared_serial_line_oe_o <= 1'b0;
            shared_serial_line_o <= 1'b0;
        end else begin
            shared_serial_line_oe_o <= any_sel && state == codec_cmd_pkg::ST_RDATA;
            shared_serial_line_o <= dout;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings shared by both channels
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mclk_4m_o <= 1'b0;
            launch_rise_o <= 1'b0;
        end else if (exec && rx_byte == codec_cmd_pkg::CMD_MCLK_2M) begin
            mclk_4m_o <= 1'b0;
        end else if (exec && rx_byte == codec_cmd_pkg::CMD_MCLK_4M) begin
            mclk_4m_o <= 1'b1;
        end else if (wr_exec && cmd == codec_cmd_pkg::CMD_WR_CLK_SLOT) begin
            launch_rise_o <= rx_byte[codec_cmd_pkg::CLK_EDGE_BIT];
        end
    end

    // per-channel settings; serial clock edges alone never reach here
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int c = 0; c < 2; c++) begin
                chan_cfg_o[c] <= '0;
                chan_cfg_o[c].tx_slot <= codec_cmd_pkg::SLOT_RESET;
                chan_cfg_o[c].rx_slot <= codec_cmd_pkg::SLOT_RESET;
                chan_cfg_o[c].gains <= codec_cmd_pkg::GAINS_RESET;
                chan_cfg_o[c].hpf_on <= 1'b1;
                chan_cfg_o[c].scale_cutoff <= 1'b1;
                line_latch[c] <= LINE_PINS'(codec_cmd_pkg::LINE_RESET);
                line_dir[c] <= LINE_PINS'(codec_cmd_pkg::LINE_RESET);
                frame_cnt[c] <= 2'h0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (chan_cfg_o[c].active && !chan_cfg_o[c].tx_valid && frame_rise) begin
                    frame_cnt[c] <= frame_cnt[c] + 2'h1;
                    if (frame_cnt[c] + 2'h1 == codec_cmd_pkg::FRAMES_TO_VALID) begin
                        chan_cfg_o[c].tx_valid <= 1'b1;
                    end
                end
                if (exec && chan_mask[c]) begin
                    unique case (rx_byte)
                        codec_cmd_pkg::CMD_DEACTIVATE: begin
                            chan_cfg_o[c].active <= 1'b0;
                            chan_cfg_o[c].tx_valid <= 1'b0;
                        end
                        codec_cmd_pkg::CMD_SOFT_RESET: begin
                            chan_cfg_o[c].active <= 1'b0;
                            chan_cfg_o[c].tx_valid <= 1'b0;
                            chan_cfg_o[c].filters_on <= 1'b0;
                            chan_cfg_o[c].adaptive_on <= 1'b0;
                            chan_cfg_o[c].mu_law <= 1'b0;
                            chan_cfg_o[c].gains[codec_cmd_pkg::GAIN_TX_BIT] <= 1'b0;
                            chan_cfg_o[c].gains[codec_cmd_pkg::GAIN_RX_BIT] <= 1'b0;
                            chan_cfg_o[c].gains[4:0] <= codec_cmd_pkg::SCALE_CUTOFF;
                            chan_cfg_o[c].scale_cutoff <= 1'b1;
                            chan_cfg_o[c].loopback <= 1'b0;
                            line_dir[c] <= '0;
                            chan_cfg_o[c].rx_extra_loss <= 1'b0;
                            chan_cfg_o[c].tx_cutoff <= 1'b0;
                            chan_cfg_o[c].rx_cutoff <= 1'b0;
                            chan_cfg_o[c].hpf_on <= 1'b1;
                            chan_cfg_o[c].test_on <= 1'b0;
                        end
                        codec_cmd_pkg::CMD_NORMAL: begin
                            chan_cfg_o[c].rx_extra_loss <= 1'b0;
                            chan_cfg_o[c].tx_cutoff <= 1'b0;
                            chan_cfg_o[c].rx_cutoff <= 1'b0;
                            chan_cfg_o[c].hpf_on <= 1'b1;
                            chan_cfg_o[c].test_on <= 1'b0;
                        end
                        codec_cmd_pkg::CMD_ACTIVATE: begin
                            chan_cfg_o[c].active <= 1'b1;
                            chan_cfg_o[c].tx_valid <= 1'b0;
                            frame_cnt[c] <= 2'h0;
                        end
                        default: ;
                    endcase
                end
                if (wr_exec && chan_mask[c]) begin
                    unique case (cmd)
                        codec_cmd_pkg::CMD_WR_TX_SLOT: chan_cfg_o[c].tx_slot <= rx_byte;
                        codec_cmd_pkg::CMD_WR_RX_SLOT: chan_cfg_o[c].rx_slot <= rx_byte;
                        codec_cmd_pkg::CMD_WR_CLK_SLOT: chan_cfg_o[c].bit_offsets <= rx_byte[5:0];
                        codec_cmd_pkg::CMD_WR_GAINS: begin
                            chan_cfg_o[c].gains <= rx_byte;
                            chan_cfg_o[c].scale_cutoff <= rx_byte[4:0] == codec_cmd_pkg::SCALE_CUTOFF;
                            chan_cfg_o[c].loopback <= rx_byte[4:0] == codec_cmd_pkg::SCALE_LOOPBACK;
                        end
                        codec_cmd_pkg::CMD_WR_LINE_OUT: line_latch[c] <= rx_byte[LINE_PINS-1:0];
                        codec_cmd_pkg::CMD_WR_LINE_DIR: line_dir[c] <= rx_byte[LINE_PINS-1:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // latched values reach the pins only where the direction says output
    assign line_ctrl_pins_o = line_latch;
    assign line_ctrl_pins_oe_o = line_dir;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_short_byte_idle: assert property (finish && !whole_byte |=>
        state == codec_cmd_pkg::ST_IDLE && cmd == codec_cmd_pkg::CMD_IDLE)
        else $error("short select period not taken as idle");
    a_read_drives: assert property (start && state == codec_cmd_pkg::ST_RDATA |=> ##1 shared_serial_line_oe_o)
        else $error("read byte not driven");
    a_read_blocks: assert property (finish && whole_byte && state == codec_cmd_pkg::ST_RDATA
        && !frame_rise |=> state == codec_cmd_pkg::ST_IDLE && $stable(chan_cfg_o))
        else $error("command accepted during readout");
    a_deact_off: assert property (exec && rx_byte == codec_cmd_pkg::CMD_DEACTIVATE && chan_mask[0]
        |=> !chan_cfg_o[0].active && $stable(chan_cfg_o[0].tx_slot))
        else $error("deactivate failed");
    a_soft_reset: assert property (exec && rx_byte == codec_cmd_pkg::CMD_SOFT_RESET && chan_mask[0]
        |=> line_dir[0] == '0 && !chan_cfg_o[0].active && chan_cfg_o[0].hpf_on)
        else $error("software reset state wrong");
    a_normal_cond: assert property (exec && rx_byte == codec_cmd_pkg::CMD_NORMAL && chan_mask[1]
        |=> chan_cfg_o[1].hpf_on && !chan_cfg_o[1].test_on && !chan_cfg_o[1].rx_extra_loss)
        else $error("normal conditions not set");
    a_activate_wait: assert property (exec && rx_byte == codec_cmd_pkg::CMD_ACTIVATE
        && chan_mask[0] |=> chan_cfg_o[0].active && !chan_cfg_o[0].tx_valid)
        else $error("transmit valid too early");
    a_mclk_select: assert property (exec && rx_byte == codec_cmd_pkg::CMD_MCLK_4M |=> mclk_4m_o)
        else $error("clock select ignored");
    a_dual_write: assert property (wr_exec && chan_mask == 2'b11
        && cmd == codec_cmd_pkg::CMD_WR_TX_SLOT |=> chan_cfg_o[0].tx_slot == chan_cfg_o[1].tx_slot)
        else $error("dual write differs");
    a_idle_clock: assert property (!any_sel && !$past(any_sel) && !frame_rise
        |=> $stable(state) && $stable(chan_cfg_o))
        else $error("state changed without select");
    a_unused_zero: assert property (state == codec_cmd_pkg::ST_RDATA && cmd == codec_cmd_pkg::CMD_RD_LINE_PINS |-> load_byte[7:5] == 3'h0)
        else $error("undefined read bits not zero");

    c_read_done: cover property (finish && whole_byte && state == codec_cmd_pkg::ST_RDATA);
    c_write_done: cover property (wr_exec);
    c_dual_select: cover property (start ##1 chan_mask == 2'b11);
    c_short_byte: cover property (finish && !whole_byte);
endmodule
`default_nettype wire

// ==== verif/host_model.sv ====
/*
 * host model: drives serial clock, selects and data of the command port.
 * assumes the bench merges the shared data line from host and device.
 */
`default_nettype none
module host_model (
    // serial port pins
    output logic sclk_o,
    output logic [1:0] sel_n_o,
    output logic dat_o,
    input wire logic line_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: clock high, selects high
    initial begin
        sclk_o = 1'b1;
        sel_n_o = 2'b11;
        dat_o = 1'b0;
    end
    // one select period of n bits msb first, then released line inverted
    task automatic xfer(input logic [1:0] s, input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        sel_n_o = ~s;
        #64;
        for (int i = 7; i > 7 - n; i--) begin
            sclk_o = 1'b0;
            dat_o = tx[i];
            #32;
            sclk_o = 1'b1;
            #31;
            rx[i] = line_i;
            #1;
        end
        sel_n_o = 2'b11;
        dat_o = ~dat_o;
        #256;
    endtask
    // free-running clock with selects high
    task automatic spin(input int n);
        repeat (2 * n) #32 sclk_o = ~sclk_o;
    endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
/*
 * testbench: command sequences through the host model with expected values.
 * assumes codec_command_port and host_model compiled before it.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, rst_i = 1'b1, frame_i = 1'b0, sclk, d_host, d_dev, d_oe, m4, lr;
    logic [1:0][4:0] pins_i = '0, pins_o, pins_oe;
    logic [1:0] sel_n;
    logic [7:0] r;
    codec_cmd_pkg::chan_cfg_t [1:0] cfg;
    int err_count = 0, checked = 0;
    wire logic line = d_oe ? d_dev : d_host;
    // 125 MHz clock
    always #4 mclk_i = ~mclk_i;
    host_model host_u (.sclk_o(sclk), .sel_n_o(sel_n), .dat_o(d_host), .line_i(line));
    codec_command_port dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .serial_clock_i(sclk),
        .chan1_select_n_i(sel_n[0]), .chan2_select_n_i(sel_n[1]),
        .shared_serial_line_i(line), .shared_serial_line_o(d_dev),
        .shared_serial_line_oe_o(d_oe), .frame_marker_i(frame_i),
        .line_ctrl_pins_i(pins_i), .line_ctrl_pins_o(pins_o),
        .line_ctrl_pins_oe_o(pins_oe), .chan_cfg_o(cfg), .mclk_4m_o(m4), .launch_rise_o(lr));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // command then data byte
    task automatic wr(input logic [1:0] s, input logic [7:0] c, input logic [7:0] d);
        host_u.xfer(s, c, 8, r);
        host_u.xfer(s, d, 8, r);
    endtask
    // command then read byte, compared
    task automatic rd(input logic [1:0] s, input logic [7:0] c, input logic [7:0] e);
        host_u.xfer(s, c, 8, r);
        host_u.xfer(s, 8'h00, 8, r);
        chk(r, e);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #200us;
        err_count++;
        finish_test();
    end
    // test sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk({cfg[0].hpf_on, cfg[0].scale_cutoff, 1'b0, pins_oe[0]}, 8'hc0);
        wr(2'b01, 8'h40, 8'h85);
        rd(2'b01, 8'h41, 8'h85);
        wr(2'b10, 8'h42, 8'h7f);
        rd(2'b10, 8'h43, 8'h7f);
        host_u.spin(16);
        host_u.xfer(2'b01, 8'h41, 4, r);
        rd(2'b01, 8'h41, 8'h85);
        $display("slot test done");
        wr(2'b10, 8'h44, 8'h47);
        chk({lr, 1'b0, cfg[1].bit_offsets}, 8'h87);
        rd(2'b10, 8'h45, 8'h47);
        host_u.xfer(2'b10, 8'h12, 8, r);
        chk({7'h00, m4}, 8'h01);
        host_u.xfer(2'b01, 8'h10, 8, r);
        chk({7'h00, m4}, 8'h00);
        wr(2'b11, 8'h50, 8'h9f);
        chk(cfg[0].gains & cfg[1].gains, 8'h9f);
        rd(2'b10, 8'h51, 8'h9f);
        $display("shared test done");
        wr(2'b01, 8'h54, 8'h0a);
        wr(2'b01, 8'h52, 8'h1f);
        chk({pins_oe[0], 3'h0}, 8'h50);
        chk({3'h0, pins_o[0]}, 8'h1f);
        pins_i <= 10'h015;
        rd(2'b01, 8'h53, 8'h15);
        $display("line test done");
        host_u.xfer(2'b01, 8'h0e, 8, r);
        for (int i = 0; i < 2; i++) begin
            chk({6'h00, cfg[0].active, cfg[0].tx_valid}, 8'h02);
            @(posedge mclk_i) frame_i <= 1'b1;
            repeat (8) @(posedge mclk_i) frame_i <= 1'b0;
        end
        chk({7'h00, cfg[0].tx_valid}, 8'h01);
        host_u.xfer(2'b01, 8'h00, 8, r);
        chk({cfg[0].active, cfg[0].tx_slot[6:0]}, 8'h05);
        host_u.xfer(2'b01, 8'h02, 8, r);
        chk({cfg[0].hpf_on, cfg[0].scale_cutoff, 1'b0, pins_oe[0]}, 8'hc0);
        chk({cfg[0].gains[6:0], cfg[0].active}, 8'h00);
        chk(cfg[1].gains, 8'h9f);
        $display("state test done");
        finish_test();
    end
endmodule
`default_nettype wire
